// >>> rtl/thermal_clock_throttle_params.svh
/*
  Constants for the thermal clock throttle: register offsets, field positions,
  reset values and modulation timing.
  Assumes inclusion by bare name from the design file and the testbench.
*/
`ifndef THERMAL_CLOCK_THROTTLE_PARAMS_SVH
`define THERMAL_CLOCK_THROTTLE_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------------
`define TCT_OFS_CTRL        4'h0
`define TCT_OFS_TARGET      4'h4
`define TCT_OFS_STATUS      4'h8
`define TCT_OFS_IRQCFG      4'hC

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define TCT_CTRL_ONDEMAND_BIT 4
`define TCT_CTRL_DUTY_LSB     1
`define TCT_CTRL_DUTY_MSB     3
`define TCT_CTRL_RESET        32'h0000_0000
`define TCT_TARGET_MAX        5'h1E
`define TCT_TARGET_BASE_C     50

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TCT_CLK_PERIOD_NS     10
`define TCT_OFF_MAX_NS        3000
`define TCT_OFF_MAX_CYC       (`TCT_OFF_MAX_NS / `TCT_CLK_PERIOD_NS)
`define TCT_SLOT_CYC          (`TCT_OFF_MAX_CYC / 7)
`define TCT_THERM_ON_SLOTS    3'h3
`define TCT_HYST_CYC          1000

`endif

// >>> rtl/thermal_clock_throttle_pkg.sv
/*
  Types for the thermal clock throttle.
  Assumes the params header is on the include path.
*/
`default_nettype none
package thermal_clock_throttle_pkg;
  typedef enum logic [1:0] {
    THERM_IDLE,
    THERM_ACTIVE,
    THERM_HYST
  } therm_state_e;
endpackage
`default_nettype wire

// >>> rtl/thermal_clock_throttle.sv
/*
  Thermal clock throttle: clock gating modulation, hot indicator, trip output
  and calibrated fan threshold, with an Avalon-MM slave for software.
  Assumes temperature comparator levels synchronous to core_clk and a board
  pull-up on the hot indicator wire.
*/
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "thermal_clock_throttle_params.svh"
module thermal_clock_throttle
  import thermal_clock_throttle_pkg::*;
#(
  parameter logic [4:0] FAN_THRESHOLD = 5'h14,
  parameter int         HYST_CYC      = `TCT_HYST_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Thermal sensor levels
  input  wire logic        die_at_max,
  input  wire logic        die_catastrophic,
  input  wire logic        monitor_enable,
  // Hot indicator pin, open drain
  input  wire logic        hot_indicator_n_in,
  output logic             hot_indicator_n_out,
  output logic             hot_indicator_n_oe,
  // Trip output
  output logic             thermal_trip_n,
  // Core clock gate and interrupts
  output logic             core_clk_enable,
  input  wire logic        irq_request,
  output logic             irq_deliver,
  output logic             hot_event
);

  localparam int SLOT_CYC = `TCT_SLOT_CYC;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic addr_is(input logic [3:0] a, input logic [3:0] ofs);
    return a == ofs;
  endfunction

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [3:0]  ctrl_r;
  logic [3:0]  ctrl_nxt;
  logic [1:0]  irqcfg_r;
  logic [1:0]  irqcfg_nxt;
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        trip_r;
  logic        trip_nxt;
  logic        hot_seen_r;
  logic        hot_seen_nxt;
  logic        evt_r;
  logic        evt_nxt;
  logic        pend_r;
  logic        pend_nxt;
  therm_state_e st_r;
  therm_state_e st_nxt;
  logic [15:0] hyst_r;
  logic [15:0] hyst_nxt;
  logic [2:0]  slot_r;
  logic [2:0]  slot_nxt;
  logic [15:0] sub_r;
  logic [15:0] sub_nxt;
  logic        ena_r;
  logic        ena_nxt;
  logic        hot_req;
  logic        tcc_on;
  logic        od_on;
  logic [2:0]  duty;
  logic [4:0]  fan_val;

  // One wait state: read data comes from a flop, writes land at the answering edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata    = rdata_r;
  assign fan_val = (FAN_THRESHOLD > `TCT_TARGET_MAX) ? `TCT_TARGET_MAX : FAN_THRESHOLD;

  always_comb begin
    ctrl_nxt   = ctrl_r;
    irqcfg_nxt = irqcfg_r;
    rdata_nxt  = rdata_r;
    ack_nxt    = (avs_read | avs_write) & ~ack_r;
    if (avs_write & ack_r) begin
      if (addr_is(avs_address, `TCT_OFS_CTRL)) begin
        ctrl_nxt = avs_writedata[`TCT_CTRL_ONDEMAND_BIT:`TCT_CTRL_DUTY_LSB];
      end
      if (addr_is(avs_address, `TCT_OFS_IRQCFG)) begin
        irqcfg_nxt = avs_writedata[1:0];
      end
    end
    if (avs_read & ~ack_r) begin
      rdata_nxt = 32'h0000_0000;
      case (avs_address)
        `TCT_OFS_CTRL:   rdata_nxt = {27'h0, ctrl_r, 1'b0};
        `TCT_OFS_TARGET: rdata_nxt = {27'h0, fan_val};
        `TCT_OFS_STATUS: rdata_nxt = {28'h0, ~thermal_trip_n, od_on, tcc_on, hot_req};
        `TCT_OFS_IRQCFG: rdata_nxt = {30'h0, irqcfg_r};
        default:         rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_r   <= 4'h0;
      irqcfg_r <= 2'h0;
      ack_r    <= 1'b0;
      rdata_r  <= 32'h0000_0000;
    end else begin
      ctrl_r   <= ctrl_nxt;
      irqcfg_r <= irqcfg_nxt;
      ack_r    <= ack_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Thermal control circuit state
  // --------------------------------------------------------------------------
  // Threshold comparison lives in the sensor; STATUS bit 0 reports it, ORed with the hot indicator wire
  assign hot_req = die_at_max | ~hot_indicator_n_in;
  assign tcc_on  = monitor_enable & (st_r != THERM_IDLE);
  assign od_on   = ctrl_r[3];

  always_comb begin
    st_nxt   = st_r;
    hyst_nxt = hyst_r;
    case (st_r)
      THERM_IDLE: begin
        if (hot_req) st_nxt = THERM_ACTIVE;
      end
      THERM_ACTIVE: begin
        if (!hot_req) begin
          st_nxt   = THERM_HYST;
          hyst_nxt = 16'(HYST_CYC);
        end
      end
      THERM_HYST: begin
        if (hot_req) begin
          st_nxt = THERM_ACTIVE;
        end else if (hyst_r == 16'h0000) begin
          st_nxt = THERM_IDLE;
        end else begin
          hyst_nxt = hyst_r - 16'h0001;
        end
      end
      default: st_nxt = THERM_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r   <= THERM_IDLE;
      hyst_r <= 16'h0000;
    end else begin
      st_r   <= st_nxt;
      hyst_r <= hyst_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Modulation: eight slots per period, on for the first duty slots
  // --------------------------------------------------------------------------
  // Thermal duty is a constant and wins over the software field
  assign duty = tcc_on ? `TCT_THERM_ON_SLOTS : ctrl_r[2:0];

  always_comb begin
    sub_nxt  = sub_r;
    slot_nxt = slot_r;
    ena_nxt  = 1'b1;
    if (tcc_on | (od_on & ctrl_r[2:0] != 3'h0)) begin
      if (sub_r == 16'(SLOT_CYC - 1)) begin
        sub_nxt  = 16'h0000;
        slot_nxt = slot_r + 3'h1;
      end else begin
        sub_nxt = sub_r + 16'h0001;
      end
      ena_nxt = (slot_nxt < duty);
    end else begin
      sub_nxt  = 16'h0000;
      slot_nxt = 3'h0;
    end
    if (trip_r) ena_nxt = 1'b0;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      slot_r <= 3'h0;
      sub_r  <= 16'h0000;
      ena_r  <= 1'b1;
    end else begin
      slot_r <= slot_nxt;
      sub_r  <= sub_nxt;
      ena_r  <= ena_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Hot indicator, trip and interrupts
  // --------------------------------------------------------------------------
  always_comb begin
    trip_nxt     = trip_r | die_catastrophic;
    hot_seen_nxt = hot_req;
    evt_nxt      = (irqcfg_r[0] & hot_req & ~hot_seen_r) |
                   (irqcfg_r[1] & ~hot_req & hot_seen_r);
    // Set wins over the delivery clear
    pend_nxt     = irq_request | (pend_r & ~ena_r);
  end

  assign hot_indicator_n_out = 1'b0;
  assign hot_indicator_n_oe  = die_at_max;
  assign thermal_trip_n      = ~trip_r;
  assign core_clk_enable     = ena_r;
  assign irq_deliver         = pend_r & ena_r;
  assign hot_event           = evt_r;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      trip_r     <= 1'b0;
      hot_seen_r <= 1'b0;
      evt_r      <= 1'b0;
      pend_r     <= 1'b0;
    end else begin
      trip_r     <= trip_nxt;
      hot_seen_r <= hot_seen_nxt;
      evt_r      <= evt_nxt;
      pend_r     <= pend_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  property p_trip_sticky;
    @(posedge core_clk) disable iff (reset) !thermal_trip_n |=> !thermal_trip_n;
  endproperty
  a_trip_sticky: assert property (p_trip_sticky) else $error("trip released");

  property p_trip_set;
    @(posedge core_clk) disable iff (reset) die_catastrophic |=> !thermal_trip_n;
  endproperty
  a_trip_set: assert property (p_trip_set) else $error("trip not set");

  property p_hot_drive;
    @(posedge core_clk) disable iff (reset) die_at_max |-> hot_indicator_n_oe;
  endproperty
  a_hot_drive: assert property (p_hot_drive) else $error("hot not driven");

  property p_engage;
    @(posedge core_clk) disable iff (reset)
      (monitor_enable && !hot_indicator_n_in) ##1 monitor_enable |-> tcc_on;
  endproperty
  a_engage: assert property (p_engage) else $error("circuit not engaged");

  property p_hyst;
    @(posedge core_clk) disable iff (reset)
      (st_r == THERM_ACTIVE && !hot_req) |=> st_r == THERM_HYST;
  endproperty
  a_hyst: assert property (p_hyst) else $error("no hysteresis");

  property p_off_max;
    @(posedge core_clk) disable iff (reset || trip_r)
      $fell(core_clk_enable) |-> ##[1:300] core_clk_enable;
  endproperty
  a_off_max: assert property (p_off_max) else $error("off too long");

  property p_irq_gate;
    @(posedge core_clk) disable iff (reset) irq_deliver |-> core_clk_enable;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while stopped");

  property p_idle_run;
    @(posedge core_clk) disable iff (reset)
      (!tcc_on && !od_on && !trip_r) |=> core_clk_enable;
  endproperty
  a_idle_run: assert property (p_idle_run) else $error("clock gated idle");

  property p_target;
    @(posedge core_clk) disable iff (reset) fan_val <= `TCT_TARGET_MAX;
  endproperty
  a_target: assert property (p_target) else $error("threshold range");

  property p_fan_read;
    @(posedge core_clk) disable iff (reset)
      (avs_read && !avs_waitrequest && addr_is(avs_address, `TCT_OFS_TARGET)) |->
      (avs_readdata[31:5] == 27'h0 && avs_readdata[4:0] <= `TCT_TARGET_MAX);
  endproperty
  a_fan_read: assert property (p_fan_read) else $error("threshold read range");

  property p_wait_one;
    @(posedge core_clk) disable iff (reset)
      ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer late");

  property p_trip_gate;
    @(posedge core_clk) disable iff (reset) !thermal_trip_n |=> !core_clk_enable;
  endproperty
  a_trip_gate: assert property (p_trip_gate) else $error("clock runs after trip");

  property p_irq_latch;
    @(posedge core_clk) disable iff (reset)
      irq_request |=> (irq_deliver || !core_clk_enable);
  endproperty
  a_irq_latch: assert property (p_irq_latch) else $error("interrupt lost");

  property p_cool_hold;
    @(posedge core_clk) disable iff (reset)
      (st_r == THERM_HYST && hyst_r != 16'h0000 && !hot_req) |=> st_r == THERM_HYST;
  endproperty
  a_cool_hold: assert property (p_cool_hold) else $error("hysteresis cut short");

  property p_od_start;
    @(posedge core_clk) disable iff (reset || !od_on || ctrl_r[2:0] == 3'h0)
      $rose(od_on) |-> ##[1:336] !core_clk_enable;
  endproperty
  a_od_start: assert property (p_od_start) else $error("on-demand not modulating");

  // Off-run length, kept only for the off-interval check; trip parks it at zero
  logic [15:0] off_run_r;
  logic [15:0] off_run_nxt;

  always_comb begin
    off_run_nxt = 16'h0000;
    if (!ena_r && !trip_r) begin
      off_run_nxt = off_run_r + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      off_run_r <= 16'h0000;
    end else begin
      off_run_r <= off_run_nxt;
    end
  end

  property p_off_run;
    @(posedge core_clk) disable iff (reset)
      off_run_r <= 16'(`TCT_OFF_MAX_CYC);
  endproperty
  a_off_run: assert property (p_off_run) else $error("off interval too long");

  c_tcc:  cover property (@(posedge core_clk) disable iff (reset) $rose(tcc_on));
  c_od:   cover property (@(posedge core_clk) disable iff (reset) od_on && !tcc_on && !ena_r);
  c_trip: cover property (@(posedge core_clk) disable iff (reset) $fell(thermal_trip_n));
  c_hev:  cover property (@(posedge core_clk) disable iff (reset) hot_event);

endmodule
`default_nettype wire

// >>> dv/thermal_board_model.sv
/*
  Board side of the throttle: hot indicator wire with pull-up, an external
  over-temperature source and the core supply switch.
  Assumes the device drives the wire low only while its enable is high.
*/
`timescale 1ns/1ps
`default_nettype none
module thermal_board_model (
  // Device side
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic hot_indicator_n_out,
  input  wire logic hot_indicator_n_oe,
  input  wire logic thermal_trip_n,
  // Board side
  input  wire logic ext_hot,
  output logic      hot_indicator_n,
  output logic      core_supply_on
);
  // ---------------------------------------------------------------
  // Wire and supply
  // ---------------------------------------------------------------
  // Pull-up wins only when nobody pulls low
  assign hot_indicator_n = !((hot_indicator_n_oe && !hot_indicator_n_out) || ext_hot);
  // Supply stays off once trip is seen; only reset restores it
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) core_supply_on <= 1'b1;
    else if (thermal_trip_n === 1'b0) core_supply_on <= 1'b0;
  end
endmodule
`default_nettype wire

// >>> dv/thermal_clock_throttle_tb.sv
/*
  Self-checking bench: register access, clock modulation, hysteresis,
  hot indicator, interrupt gating and trip.
  Assumes a 100 MHz core clock and the board model beside the design.
*/
`timescale 1ns/1ps
`default_nettype none
`include "thermal_clock_throttle_params.svh"
module thermal_clock_throttle_tb;
  import thermal_clock_throttle_pkg::*;
  localparam int S = `TCT_SLOT_CYC;
  localparam int P = 8 * S;
  logic core_clk, reset, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic die_at_max, die_catastrophic, monitor_enable, hot_n, oe, hout;
  logic thermal_trip_n, core_clk_enable, irq_request, irq_deliver;
  logic hot_event, ext_hot, supply_on;
  int n_fail, comparisons, on, offmax, ev, bad, dl;
  thermal_clock_throttle #(.FAN_THRESHOLD(5'h1E), .HYST_CYC(10)) u_dut (
    .core_clk(core_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .die_at_max(die_at_max), .die_catastrophic(die_catastrophic),
    .monitor_enable(monitor_enable), .hot_indicator_n_in(hot_n),
    .hot_indicator_n_out(hout), .hot_indicator_n_oe(oe),
    .thermal_trip_n(thermal_trip_n), .core_clk_enable(core_clk_enable),
    .irq_request(irq_request), .irq_deliver(irq_deliver), .hot_event(hot_event));
  thermal_board_model u_board (
    .core_clk(core_clk), .reset(reset), .hot_indicator_n_out(hout),
    .hot_indicator_n_oe(oe), .thermal_trip_n(thermal_trip_n),
    .ext_hot(ext_hot), .hot_indicator_n(hot_n), .core_supply_on(supply_on));
  // ---------------------------------------------------------------
  // Clock and monitors
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Delivery while clocks are stopped would run code in an off slot
  always @(negedge core_clk) begin
    if (irq_deliver === 1'b1 && core_clk_enable !== 1'b1) bad++;
    if (hot_event === 1'b1) ev++;
    if (irq_deliver === 1'b1) dl++;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("fails %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Request held until the edge that sees waitrequest low
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      n++;
      @(posedge core_clk);
    end
    if (n == 50) chk(32'h1, 32'h0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // One full period gives the on count whatever the phase
  task automatic meas();
    int run;
    on = 0;
    offmax = 0;
    run = 0;
    repeat (4) @(posedge core_clk);
    repeat (P) begin
      @(negedge core_clk);
      if (core_clk_enable === 1'b1) begin
        on++;
        run = 0;
      end else begin
        run++;
        if (run > offmax) offmax = run;
      end
    end
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    #400000;
    n_fail++;
    give_verdict();
  end
  initial begin
    n_fail = 0; comparisons = 0; ev = 0; bad = 0; dl = 0;
    reset = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0;
    avs_writedata = 32'h0; die_at_max = 1'b0; die_catastrophic = 1'b0;
    monitor_enable = 1'b1; irq_request = 1'b0; ext_hot = 1'b0;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    acc(1'b0, `TCT_OFS_CTRL, 32'h0);
    chk(q, `TCT_CTRL_RESET);
    acc(1'b1, `TCT_OFS_TARGET, 32'h0);
    acc(1'b0, `TCT_OFS_TARGET, 32'h0);
    chk(q, 32'h0000_001E);
    chk(q + `TCT_TARGET_BASE_C, 32'd80);
    acc(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    acc(1'b1, `TCT_OFS_IRQCFG, 32'h3);
    for (int d = 1; d < 8; d++) begin
      acc(1'b1, `TCT_OFS_CTRL, 32'h10 | (d << 1));
      meas();
      chk(on, d * S);
    end
    acc(1'b1, `TCT_OFS_CTRL, 32'h10);
    meas();
    chk(on, P);
    acc(1'b1, `TCT_OFS_CTRL, 32'h14);
    acc(1'b0, `TCT_OFS_CTRL, 32'h0);
    chk(q, 32'h0000_0014);
    ev = 0;
    @(posedge core_clk) die_at_max <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk(oe, 1'b1);
    chk(hout, 1'b0);
    @(posedge core_clk) irq_request <= 1'b1;
    @(posedge core_clk) irq_request <= 1'b0;
    meas();
    chk(on, 3 * S);
    chk(offmax <= `TCT_OFF_MAX_CYC, 1'b1);
    chk(bad, 0);
    chk(dl, 1);
    acc(1'b0, `TCT_OFS_STATUS, 32'h0);
    chk(q[2:0], 3'h7);
    @(posedge core_clk) die_at_max <= 1'b0;
    acc(1'b0, `TCT_OFS_STATUS, 32'h0);
    chk(q[1], 1'b1);
    repeat (40) @(posedge core_clk);
    acc(1'b0, `TCT_OFS_STATUS, 32'h0);
    chk(q[1], 1'b0);
    meas();
    chk(on, 2 * S);
    chk(ev, 2);
    acc(1'b1, `TCT_OFS_CTRL, 32'h0);
    acc(1'b1, `TCT_OFS_IRQCFG, 32'h1);
    acc(1'b0, `TCT_OFS_IRQCFG, 32'h0);
    chk(q, 32'h0000_0001);
    ev = 0;
    @(posedge core_clk) ext_hot <= 1'b1;
    repeat (5) @(posedge core_clk);
    acc(1'b0, `TCT_OFS_STATUS, 32'h0);
    chk(q[1:0], 2'h3);
    meas();
    chk(on, 3 * S);
    @(posedge core_clk) ext_hot <= 1'b0;
    monitor_enable <= 1'b0;
    die_catastrophic <= 1'b1;
    repeat (3) @(posedge core_clk);
    die_catastrophic <= 1'b0;
    repeat (10) @(negedge core_clk);
    chk(thermal_trip_n, 1'b0);
    chk(supply_on, 1'b0);
    chk(core_clk_enable, 1'b0);
    chk(ev, 1);
    acc(1'b0, `TCT_OFS_STATUS, 32'h0);
    chk(q[3], 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
